/* design/nvsram_host.v */
// Purpose: Host controller driving a 512 x 8 shadowed SRAM over its strobes.
// Assumes: Device is asynchronous; all timing is by cycle counts at 125 MHz.
// Notes: A request is taken only when idle; busy covers every operation.
// Function
// RULE1: Read: chip select and output drive low, write and nonvolatile select high.
// RULE2: Write: chip select and write strobe low, nonvolatile select high.
// RULE3: Nine address bits select one byte of 512.
// RULE4: Recall copies shadow array into RAM within 5 microseconds.
// RULE5: Store copies RAM into shadow array within 10 ms.
// RULE6: Device recalls automatically at power-up whatever the strobes.
// RULE7: Write strobe pulses under 20 ns are ignored by the device.
// RULE8: Combined write and nonvolatile pulses under 20 ns start no store.
// RULE9: Inhibit levels during power transitions prevent stores.
// RULE10: Output drive low blocks any store.
// RULE11: Device data pins float when chip select or output drive high.
// RULE12: Hold nonvolatile select, write and chip select low for store pulse.
// RULE13: After store start keep nonvolatile select and chip select high 10 ms.
// RULE14: During store, output drive and write strobe may go low.
// RULE15: Hold nonvolatile select, output drive, chip select low for recall pulse.
// RULE16: After recall start keep nonvolatile select and chip select high 5 us.
// RULE17: During recall, output drive and write strobe may go low.
// RULE18: Nonvolatile select gates all shadow array accesses.
// RULE19: Device ignores RAM requests while store or recall runs.
// RULE20: Never drive all four strobes low at once.
`timescale 1ns/1ns
`include "nvsram_host_consts.vh"
module nvsram_host #(
	parameter STORE_CYCLES   = `CYC_UP(`STORE_DURATION_NS),
	parameter POWERUP_CYCLES = `CYC_UP(`POWERUP_RECALL_NS)
) (
	input  wire                clock,
	input  wire                rst_n,
	input  wire                req_valid,
	input  wire [2:0]          req_op,
	input  wire [`ADDR_W-1:0]  req_addr,
	input  wire [`DATA_W-1:0]  req_wdata,
	output reg                 busy,
	output reg                 done,
	output reg  [`DATA_W-1:0]  rd_data,
	output reg                 chip_select_n,
	output reg                 output_drive_n,
	output reg                 write_strobe_n,
	output reg                 nonvolatile_select_n,
	output reg  [`ADDR_W-1:0]  word_address,
	output reg  [`DATA_W-1:0]  data_pins_out,
	output reg                 data_pins_oe_n,
	input  wire [`DATA_W-1:0]  data_pins_in
);
	localparam [31:0] STORE_C   = STORE_CYCLES;
	localparam [31:0] PWRUP_C   = POWERUP_CYCLES;
	localparam [31:0] SPULSE_C  = `CYC_UP(`STORE_PULSE_MIN_NS);
	localparam [31:0] RPULSE_C  = `CYC_UP(`RECALL_PULSE_MIN_NS);
	localparam [31:0] WPULSE_C  = `CYC_UP(`WRITE_PULSE_MIN_NS);
	localparam [31:0] RDACC_C   = `CYC_UP(`READ_ACCESS_NS);
	localparam [31:0] RECALL_C  = `CYC_UP(`RECALL_DURATION_NS);
	localparam [5:0] S_PWRUP  = 6'h01;
	localparam [5:0] S_IDLE   = 6'h02;
	localparam [5:0] S_PULSE  = 6'h04;
	localparam [5:0] S_WAIT   = 6'h08;
	localparam [5:0] S_SAMPLE = 6'h10;
	localparam [5:0] S_END    = 6'h20;

	reg  [5:0]          state_r;
	reg  [2:0]          op_r;
	reg  [31:0]         cnt_r;
	wire [`DATA_W-1:0]  data_sync;

	function op_legal;
		input [2:0] op;
		begin
			op_legal = (op == `OP_READ) || (op == `OP_WRITE) ||
				(op == `OP_STORE) || (op == `OP_RECALL);
		end
	endfunction

	pin_sync3 #(.WIDTH(`DATA_W)) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.din   (data_pins_in),
		.dout  (data_sync)
	);

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r              <= S_PWRUP;
			op_r                 <= `OP_IDLE;
			cnt_r                <= 32'h0;
			busy                 <= 1'b1;
			done                 <= 1'b0;
			rd_data              <= {`DATA_W{1'b0}};
			chip_select_n        <= 1'b1;
			output_drive_n       <= 1'b1;
			write_strobe_n       <= 1'b1;
			nonvolatile_select_n <= 1'b1;
			word_address         <= {`ADDR_W{1'b0}};
			data_pins_out        <= {`DATA_W{1'b0}};
			data_pins_oe_n       <= 1'b1;
		end
		else
		begin
			done <= 1'b0;
			case (state_r)
				S_PWRUP:
				begin
					// Waits out the automatic power-up recall before use.
					if (cnt_r + 32'h1 >= PWRUP_C) // RULE6
					begin
						cnt_r   <= 32'h0;
						busy    <= 1'b0;
						state_r <= S_IDLE;
					end
					else
						cnt_r <= cnt_r + 32'h1;
				end
				S_IDLE:
				begin
					if (req_valid && op_legal(req_op))
					begin
						op_r          <= req_op;
						busy          <= 1'b1;
						cnt_r         <= 32'h0;
						word_address  <= req_addr; // RULE3
						chip_select_n <= 1'b0;
						state_r       <= S_PULSE;
						case (req_op)
							`OP_READ:
								output_drive_n <= 1'b0; // RULE1
							`OP_WRITE:
							begin
								write_strobe_n <= 1'b0; // RULE2 RULE7
								data_pins_out  <= req_wdata;
								data_pins_oe_n <= 1'b0;
							end
							`OP_STORE:
							begin
								// Output drive stays high or the store is blocked.
								nonvolatile_select_n <= 1'b0; // RULE12 RULE10 RULE18
								write_strobe_n       <= 1'b0; // RULE8 RULE20
							end
							default:
							begin
								nonvolatile_select_n <= 1'b0; // RULE15 RULE18 RULE20
								output_drive_n       <= 1'b0;
							end
						endcase
					end
				end
				S_PULSE:
				begin
					cnt_r <= cnt_r + 32'h1;
					if (op_r == `OP_READ)
					begin
						if (cnt_r + 32'h1 >= RDACC_C)
							state_r <= S_SAMPLE;
					end
					else if (cnt_r + 32'h1 >= ((op_r == `OP_WRITE) ? WPULSE_C :
						(op_r == `OP_STORE) ? SPULSE_C : RPULSE_C))
					begin
						// All strobes rise together; the array runs on alone.
						chip_select_n        <= 1'b1; // RULE13 RULE16
						nonvolatile_select_n <= 1'b1;
						write_strobe_n       <= 1'b1;
						output_drive_n       <= 1'b1;
						data_pins_oe_n       <= 1'b1;
						cnt_r                <= 32'h0;
						state_r              <= (op_r == `OP_WRITE) ? S_END : S_WAIT;
					end
				end
				S_SAMPLE:
				begin
					// Three more cycles let the synchroniser settle on the byte.
					cnt_r <= cnt_r + 32'h1;
					if (cnt_r + 32'h1 >= RDACC_C + `SYNC_SETTLE_CYCLES) // RULE1 RULE11
					begin
						rd_data        <= data_sync;
						chip_select_n  <= 1'b1;
						output_drive_n <= 1'b1;
						state_r        <= S_END;
					end
				end
				S_WAIT:
				begin
					// No access is issued until the store or recall has run out.
					if (cnt_r + 32'h1 >= ((op_r == `OP_STORE) ? STORE_C : RECALL_C)) // RULE4 RULE5 RULE19
						state_r <= S_END;
					else
						// Output drive and write strobe stay high, though they may go low.
						cnt_r <= cnt_r + 32'h1; // RULE14 RULE17
				end
				S_END:
				begin
					busy    <= 1'b0;
					done    <= 1'b1;
					op_r    <= `OP_IDLE;
					cnt_r   <= 32'h0;
					state_r <= S_IDLE;
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end
endmodule // nvsram_host

/* design/nvsram_host_consts.vh */
// Purpose: Constants for the shadowed SRAM host controller.
// Assumes: 125 MHz clock, 8 ns period.
// Notes: Times are in ns; cycle counts derive from them.
`ifndef NVSRAM_HOST_CONSTS_VH
`define NVSRAM_HOST_CONSTS_VH
`define CLK_PERIOD_NS 8
`define STORE_PULSE_MIN_NS 120
`define RECALL_PULSE_MIN_NS 120
`define WRITE_PULSE_MIN_NS 120
`define READ_ACCESS_NS 200
`define RECALL_DURATION_NS 5000
`define STORE_DURATION_NS 10000000
`define POWERUP_RECALL_NS 5000
`define SYNC_SETTLE_CYCLES 32'h3
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_IDLE 3'h0
`define OP_READ 3'h1
`define OP_WRITE 3'h2
`define OP_STORE 3'h3
`define OP_RECALL 3'h4
`define DATA_W 8
`define ADDR_W 9
`endif

/* design/pin_sync3.v */
// Purpose: Three-flop synchroniser with agreement filter.
// Assumes: Input is asynchronous to clock.
// Notes: Output changes once the second and third flops agree.
`timescale 1ns/1ns
module pin_sync3 #(
	parameter WIDTH = 8
) (
	input  wire             clock,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] s1_r;
	reg [WIDTH-1:0] s2_r;
	reg [WIDTH-1:0] s3_r;
	wire [WIDTH-1:0] agree;
	genvar i;
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			s1_r <= {WIDTH{1'b0}};
			s2_r <= {WIDTH{1'b0}};
			s3_r <= {WIDTH{1'b0}};
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_agree
			assign agree[i] = (s2_r[i] == s3_r[i]);
		end
	endgenerate
	// Each bit follows the third flop only where the last two flops agree.
	always @(posedge clock)
	begin
		if (!rst_n)
			dout <= {WIDTH{1'b0}};
		else
			dout <= (s3_r & agree) | (dout & ~agree);
	end
endmodule // pin_sync3

/* tb/nvsram_host_checker.sv */
// Purpose: Port checker for the host controller.
// Assumes: One clock domain.
// Notes: Bound to every controller instance.
`timescale 1ns/1ns
module nvsram_host_checker (
	input wire clock,
	input wire rst_n,
	input wire busy,
	input wire chip_select_n,
	input wire output_drive_n,
	input wire write_strobe_n,
	input wire nonvolatile_select_n,
	input wire data_pins_oe_n
);
	reg [7:0] low_r;
	always @(posedge clock)
	begin
		low_r <= nonvolatile_select_n ? 8'h00 : low_r + 8'h01;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_not_all; chip_select_n | output_drive_n | write_strobe_n | nonvolatile_select_n;
	endproperty
	a_not_all: assert property (p_not_all) else $error("All strobes low.");
	property p_read; !output_drive_n && nonvolatile_select_n |-> write_strobe_n && data_pins_oe_n;
	endproperty
	a_read: assert property (p_read) else $error("Bad read strobes.");
	property p_write; !write_strobe_n && nonvolatile_select_n |-> !chip_select_n && !data_pins_oe_n;
	endproperty
	a_write: assert property (p_write) else $error("Bad write strobes.");
	property p_store; !write_strobe_n && !nonvolatile_select_n |-> output_drive_n && !chip_select_n;
	endproperty
	a_store: assert property (p_store) else $error("Bad store strobes.");
	property p_recall; !output_drive_n && !nonvolatile_select_n |-> write_strobe_n && data_pins_oe_n;
	endproperty
	a_recall: assert property (p_recall) else $error("Bad recall strobes.");
	property p_pulse; $rose(nonvolatile_select_n) |-> low_r >= 8'h0F;
	endproperty
	a_pulse: assert property (p_pulse) else $error("Short store or recall pulse.");
	property p_hold;
		$rose(nonvolatile_select_n) |-> (nonvolatile_select_n && chip_select_n) throughout
			(##[0:800] !busy);
	endproperty
	a_hold: assert property (p_hold) else $error("Strobes low during busy wait.");
	property p_idle; !busy |-> chip_select_n && output_drive_n && data_pins_oe_n;
	endproperty
	a_idle: assert property (p_idle) else $error("Strobe active while idle.");
	c_store: cover property (!write_strobe_n && !nonvolatile_select_n);
	c_recall: cover property (!output_drive_n && !nonvolatile_select_n);
	c_write: cover property (!write_strobe_n && nonvolatile_select_n);
endmodule // nvsram_host_checker
bind nvsram_host nvsram_host_checker chk_u (.clock(clock), .rst_n(rst_n), .busy(busy),
	.chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
	.write_strobe_n(write_strobe_n), .nonvolatile_select_n(nonvolatile_select_n),
	.data_pins_oe_n(data_pins_oe_n));

/* tb/nvsram_dev_model.sv */
// Purpose: Behavioural shadowed SRAM.
// Assumes: Store time matches the bench's shortened store wait.
// Notes: Released data lines show the inverse of the last value read.
`timescale 1ns/1ns
module nvsram_dev_model #(
	parameter STORE_NS  = 400,
	parameter RECALL_NS = 5000
) (
	input  wire       clock,
	input  wire       chip_select_n,
	input  wire       output_drive_n,
	input  wire       write_strobe_n,
	input  wire       nonvolatile_select_n,
	input  wire [8:0] word_address,
	input  wire [7:0] data_pins_out,
	output wire [7:0] data_pins_in
);
	localparam       GLITCH_NS = 20;
	localparam [1:0] M_NONE    = 2'h0;
	localparam [1:0] M_WR      = 2'h1;
	localparam [1:0] M_ST      = 2'h2;
	localparam [1:0] M_RC      = 2'h3;
	reg [7:0] ram [0:511];
	reg [7:0] shadow [0:511];
	reg [7:0] last_r;
	reg [7:0] data_r;
	reg [8:0] addr_r;
	reg [1:0] mode_r;
	reg [1:0] cur;
	time      start_t;
	time      busy_t;
	integer   violations;
	integer   i;
	wire      rd_en = !chip_select_n && !output_drive_n && write_strobe_n && nonvolatile_select_n;
	initial
	begin
		last_r = 8'h00;
		data_r = 8'h00;
		addr_r = 9'h000;
		mode_r = M_NONE;
		cur = M_NONE;
		start_t = 0;
		busy_t = 0;
		violations = 0;
		for (i = 0; i < 512; i = i + 1)
		begin
			shadow[i] = i[7:0] ^ 8'h3C;
			ram[i] = shadow[i];
		end
	end
	always @(posedge clock)
	begin
		if (rd_en)
			last_r <= data_pins_in;
	end
	assign data_pins_in = rd_en ? ram[word_address] : ~last_r;
	// Strobes are sampled mid-cycle; a mode acts when its pulse ends.
	always @(negedge clock)
	begin
		cur = M_NONE;
		if (!chip_select_n && !write_strobe_n && nonvolatile_select_n)
			cur = M_WR;
		else if (!chip_select_n && !write_strobe_n && output_drive_n)
			cur = M_ST;
		else if (!chip_select_n && !output_drive_n && !nonvolatile_select_n && write_strobe_n)
			cur = M_RC;
		if ($time < busy_t && (cur == M_WR || rd_en))
			violations = violations + 1;
		if (cur != mode_r)
		begin
			if (mode_r != M_NONE && $time - start_t >= GLITCH_NS)
			begin
				if (mode_r == M_WR && $time >= busy_t)
					ram[addr_r] = data_r;
				if (mode_r == M_ST)
				begin
					for (i = 0; i < 512; i = i + 1)
						shadow[i] = ram[i];
					busy_t = $time + STORE_NS;
				end
				if (mode_r == M_RC)
				begin
					for (i = 0; i < 512; i = i + 1)
						ram[i] = shadow[i];
					busy_t = $time + RECALL_NS;
				end
			end
			mode_r = cur;
			start_t = $time;
		end
		if (cur == M_WR)
		begin
			addr_r = word_address;
			data_r = data_pins_out;
		end
	end
endmodule // nvsram_dev_model

/* tb/nvsram_host_tb.sv */
// Purpose: Self-checking bench for the host controller.
// Assumes: Shortened store and power-up counts.
// Notes: Rows hold op, address and data or expected read byte.
`timescale 1ns/1ns
module nvsram_host_tb;
	reg        clock;
	reg        rst_n;
	reg        req_valid;
	reg  [2:0] req_op;
	reg  [8:0] req_addr;
	reg  [7:0] req_wdata;
	wire       busy, done, cs_n, od_n, we_n, nv_n, oe_n;
	wire [7:0] rd_data, dout, din;
	wire [8:0] addr;
	integer    mismatches, samples_checked, k, n;
	reg [19:0] rows [0:8];
	nvsram_host #(.STORE_CYCLES(50), .POWERUP_CYCLES(10)) dut_u (.clock(clock), .rst_n(rst_n),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
		.busy(busy), .done(done), .rd_data(rd_data), .chip_select_n(cs_n), .output_drive_n(od_n),
		.write_strobe_n(we_n), .nonvolatile_select_n(nv_n), .word_address(addr),
		.data_pins_out(dout), .data_pins_oe_n(oe_n), .data_pins_in(din));
	nvsram_dev_model dev_u (.clock(clock), .chip_select_n(cs_n), .output_drive_n(od_n),
		.write_strobe_n(we_n), .nonvolatile_select_n(nv_n), .word_address(addr),
		.data_pins_out(dout), .data_pins_in(din));
	always #4 clock = ~clock;
	task print_verdict;
	begin
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			$display("MISMATCH %0s exp %h got %h", nm, e, g);
			mismatches = mismatches + 1;
		end
	end
	endtask
	task go(input [19:0] r);
	begin
		@(posedge clock);
		#1 req_valid = 1'b1;
		{req_op, req_addr, req_wdata} = r;
	end
	endtask
	task fin;
	begin
		@(posedge clock);
		#1 req_valid = 1'b0;
		for (n = 0; n < 3000 && done !== 1'b1; n = n + 1)
			@(posedge clock) #1;
		if (done !== 1'b1)
		begin
			$display("MISMATCH done exp 1 got %b", done);
			mismatches = mismatches + 1;
			disable run_b;
		end
	end
	endtask
	task wait_idle;
	begin
		for (n = 0; n < 100 && busy !== 1'b0; n = n + 1)
			@(posedge clock) #1;
		if (busy !== 1'b0)
		begin
			$display("MISMATCH busy exp 0 got %b", busy);
			mismatches = mismatches + 1;
			disable run_b;
		end
	end
	endtask
	initial
	begin
		rows[0] = 20'h400A5; rows[1] = 20'h5FF5A; rows[2] = 20'h200A5; rows[3] = 20'h3FF5A;
		rows[4] = 20'h2102C; rows[5] = 20'h60000; rows[6] = 20'h40000; rows[7] = 20'h80000;
		rows[8] = 20'h200A5;
		clock = 1'b0; rst_n = 1'b0; req_valid = 1'b0; {req_op, req_addr, req_wdata} = 20'h00000;
		mismatches = 0; samples_checked = 0;
		begin : run_b
			repeat (5) @(posedge clock);
			#1 chk("reset", 8'h5F, {1'b0, oe_n, done, busy, cs_n, od_n, we_n, nv_n});
			rst_n = 1'b1;
			wait_idle;
			for (k = 0; k < 9; k = k + 1)
			begin
				go(rows[k]);
				fin;
				if (rows[k][19:17] == 3'h1) chk("row", rows[k][7:0], rd_data);
			end
			go(20'h80000);
			go(20'h5FFFF);
			fin;
			go(20'h3FF5A);
			fin;
			chk("refused", 8'h5A, rd_data);
			rst_n = 1'b0;
			repeat (5) @(posedge clock);
			#1 chk("reset2", 8'h5F, {1'b0, oe_n, done, busy, cs_n, od_n, we_n, nv_n});
			chk("rdclr", 8'h00, rd_data);
			rst_n = 1'b1;
			wait_idle;
			go(20'h200A5);
			fin;
			chk("rst_read", 8'hA5, rd_data);
			chk("viol", 8'h00, dev_u.violations[7:0]);
		end
		print_verdict;
	end
endmodule // nvsram_host_tb
